// File: hw/prsl_dev.sv
/*
 * Device end: serial load port, sigma-delta seed and resync timer.
 * Assumes link wires are asynchronous to clk and sampled twice.
 */
// The serial load port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module prsl_dev
   import prsl_pkg::*;
#(
   parameter int CMP_DIV = CMP_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Link
   prsl_if.device link,
   // Loose control bit
   input wire logic dither_en,
   // Status outputs
   output logic sync_pulse_r,
   output logic resync_r,
   output logic wide_bw_r,
   output logic sigma_carry_r,
   output logic [FIELD_BITS-1:0] phase_num_r,
   output logic [FIELD_BITS-1:0] phase_den_r,
   output logic [1:0] mode_r
);
   // ****************************************************
   // Declarations
   // ****************************************************
   logic [2:0] sclk_s, sdata_s, latch_s;
   logic sclk_rise, latch_rise;
   logic [WORD_BITS-1:0] shift_r;
   logic [WORD_BITS-1:0] latch_r [NUM_LATCH];
   logic [FIELD_BITS-1:0] frac_w, den_w, phase_w, cdiv_w;
   logic [FIELD_BITS-1:0] den_eff, cdiv_eff;
   logic [1:0] mode_w;
   logic [7:0] cmp_cnt_r;
   logic cmp_en_r;
   logic [FIELD_BITS-1:0] den_cnt_r, div_cnt_r;
   logic tick;
   logic [1:0] sync_cnt_r;
   logic [FIELD_BITS-1:0] acc_r;
   logic [FIELD_BITS:0] acc_sum;
   logic [FIELD_BITS-1:0] lfsr_r;
   logic timer_on;

   generate
      if (CMP_DIV < 1 || CMP_DIV > 255) begin : g_chk
         $error("prsl_dev: CMP_DIV out of range");
      end
   endgenerate

   // ****************************************************
   // Serial load port
   // ****************************************************
   // Two-flop synchronisers, third flop for edge detect
   always_ff @(posedge clk) begin
      if (reset) begin
         sclk_s <= 3'h0;
         sdata_s <= 3'h0;
         latch_s <= 3'h7;
      end else begin
         sclk_s <= {sclk_s[1:0], link.sclk};
         sdata_s <= {sdata_s[1:0], link.sdata};
         latch_s <= {latch_s[1:0], link.latch_strobe};
      end
   end
   assign sclk_rise = sclk_s[1] & ~sclk_s[2];
   assign latch_rise = latch_s[1] & ~latch_s[2];

   // Shift register, one bit per serial clock rise
   always_ff @(posedge clk) begin
      if (reset) begin
         shift_r <= LATCH_RESET;
      end else if (sclk_rise) begin
         shift_r <= {shift_r[WORD_BITS-2:0], sdata_s[1]}; // R10
      end
   end

   // Latch file, addressed by the low word bits
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < NUM_LATCH; i++) begin
            latch_r[i] <= LATCH_RESET;
         end
      end else if (latch_rise) begin
         for (int i = 0; i < NUM_LATCH; i++) begin
            if (shift_r[ADDR_MSB:ADDR_LSB] == 3'(i)) begin
               latch_r[i] <= shift_r; // R10
            end
         end
      end
   end

   // Field extraction
   assign frac_w = latch_r[REG_FRAC][FRAC_LSB +: FIELD_BITS];
   assign den_w = latch_r[REG_DEN][DEN_LSB +: FIELD_BITS]; // R6
   assign phase_w = latch_r[REG_DEN][PHASE_LSB +: FIELD_BITS];
   assign cdiv_w = latch_r[REG_CTRL][CDIV_LSB +: FIELD_BITS]; // R5
   assign mode_w = latch_r[REG_CTRL][MODE_LSB +: 2];
   // Zero divider or modulus acts as one
   assign cdiv_eff = (cdiv_w == 12'h000) ? 12'h001 : cdiv_w; // R5
   assign den_eff = (den_w == 12'h000) ? 12'h001 : den_w;
   assign timer_on = (mode_w == MODE_RESYNC) || (mode_w == MODE_FASTLOCK);

   // ****************************************************
   // Comparison-rate enable
   // ****************************************************
   always_ff @(posedge clk) begin
      if (reset || cmp_cnt_r == 8'(CMP_DIV - 1)) begin
         cmp_cnt_r <= 8'h00;
      end else begin
         cmp_cnt_r <= cmp_cnt_r + 8'h01;
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         cmp_en_r <= 1'b0;
      end else begin
         cmp_en_r <= (cmp_cnt_r == 8'(CMP_DIV - 1));
      end
   end

   // ****************************************************
   // Resync and fast-lock timer
   // ****************************************************
   // Period of divider times modulus comparison periods
   assign tick = timer_on && cmp_en_r && !latch_rise
                 && den_cnt_r == den_eff - 12'h001
                 && div_cnt_r == cdiv_eff - 12'h001; // R4
   always_ff @(posedge clk) begin
      if (reset || latch_rise || !timer_on) begin
         den_cnt_r <= 12'h000; // R15
         div_cnt_r <= 12'h000;
      end else if (cmp_en_r) begin
         if (den_cnt_r >= den_eff - 12'h001) begin
            den_cnt_r <= 12'h000;
            if (div_cnt_r >= cdiv_eff - 12'h001) begin
               div_cnt_r <= 12'h000;
            end else begin
               div_cnt_r <= div_cnt_r + 12'h001;
            end
         end else begin
            den_cnt_r <= den_cnt_r + 12'h001;
         end
      end
   end

   // Sync pulse output in resync mode only
   always_ff @(posedge clk) begin
      if (reset) begin
         sync_pulse_r <= 1'b0;
      end else begin
         sync_pulse_r <= tick && (mode_w == MODE_RESYNC); // R3
      end
   end

   // Count syncs since strobe, second one realigns
   always_ff @(posedge clk) begin
      if (reset || latch_rise) begin
         sync_cnt_r <= 2'h0;
      end else if (tick && mode_w == MODE_RESYNC && sync_cnt_r != 2'h2) begin
         sync_cnt_r <= sync_cnt_r + 2'h1;
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         resync_r <= 1'b0;
      end else begin
         resync_r <= tick && mode_w == MODE_RESYNC
                     && sync_cnt_r == 2'h1; // R7
      end
   end

   // Wide bandwidth from strobe until the first timer expiry
   always_ff @(posedge clk) begin
      if (reset) begin
         wide_bw_r <= 1'b0;
      end else if (latch_rise) begin
         wide_bw_r <= (shift_r[ADDR_MSB:ADDR_LSB] == 3'(REG_CTRL))
                      ? (shift_r[MODE_LSB +: 2] == MODE_FASTLOCK)
                      : (mode_w == MODE_FASTLOCK); // R13
      end else if (tick || mode_w != MODE_FASTLOCK) begin
         wide_bw_r <= 1'b0; // R13
      end
   end

   // ****************************************************
   // Sigma-delta modulator
   // ****************************************************
   // Dither source
   always_ff @(posedge clk) begin
      if (reset) begin
         lfsr_r <= 12'h0001;
      end else if (cmp_en_r) begin
         lfsr_r <= {lfsr_r[10:0], lfsr_r[11] ^ lfsr_r[5]
                    ^ lfsr_r[3] ^ lfsr_r[0]};
      end
   end

   // Accumulator stepped once per comparison period
   assign acc_sum = {1'b0, acc_r} + {1'b0, frac_w};
   always_ff @(posedge clk) begin
      if (reset) begin
         acc_r <= 12'h000;
         sigma_carry_r <= 1'b0;
      end else if (latch_rise || resync_r) begin
         acc_r <= dither_en ? (lfsr_r % den_eff)
                  : (phase_w % den_eff); // R1 R12
         sigma_carry_r <= 1'b0;
      end else if (cmp_en_r) begin
         if (acc_sum >= {1'b0, den_eff}) begin // R14
            acc_r <= FIELD_BITS'(acc_sum - {1'b0, den_eff});
            sigma_carry_r <= 1'b1;
         end else begin
            acc_r <= acc_sum[FIELD_BITS-1:0];
            sigma_carry_r <= 1'b0;
         end
      end else begin
         sigma_carry_r <= 1'b0;
      end
   end

   // ****************************************************
   // Programmed phase and mode
   // ****************************************************
   // Phase is phase_num of phase_den turns
   always_ff @(posedge clk) begin
      if (reset) begin
         phase_num_r <= 12'h000;
         phase_den_r <= 12'h001;
         mode_r <= 2'h0;
      end else begin
         phase_num_r <= phase_w % den_eff; // R9
         phase_den_r <= den_eff; // R9
         mode_r <= mode_w;
      end
   end
endmodule : prsl_dev

// File: hw/prsl_wr.sv
/*
 * Serial writer end: sends one 32-bit latch word as four bytes.
 * Assumes a single clk, with the serial clock made by a divider.
 */
`timescale 1ns/1ps
module prsl_wr
   import prsl_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // User side
   input wire logic start,
   input wire logic [WORD_BITS-1:0] word,
   output logic busy_r,
   output logic done_r,
   // Link
   prsl_if.writer link
);
   // ****************************************************
   // Declarations
   // ****************************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LEAD = 2'b01,
      ST_BIT = 2'b10,
      ST_LATCH = 2'b11
   } prsl_wst_type;
   prsl_wst_type state_r;
   logic [15:0] half_r;
   logic half_done;
   logic [5:0] bit_r;
   logic [WORD_BITS-1:0] sh_r;
   logic sclk_r;
   logic sdata_r;
   logic latch_r;

   generate
      if (HALF_CYC < 2 || HALF_CYC > 65535) begin : g_chk
         $error("prsl_wr: HALF_CYC out of range");
      end
   endgenerate

   // Half serial-clock period divider
   assign half_done = (half_r == 16'(HALF_CYC - 1));
   always_ff @(posedge clk) begin
      if (reset || state_r == ST_IDLE || half_done) begin
         half_r <= 16'h0000;
      end else begin
         half_r <= half_r + 16'h0001;
      end
   end

   // Transfer sequence, data changes while serial clock is low
   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= ST_IDLE;
         sclk_r <= 1'b0;
         sdata_r <= 1'b0;
         latch_r <= 1'b1;
         bit_r <= 6'h00;
         sh_r <= LATCH_RESET;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  latch_r <= 1'b0; // R11
                  sh_r <= word;
                  bit_r <= 6'h00;
                  busy_r <= 1'b1;
                  state_r <= ST_LEAD;
               end
            end
            ST_LEAD: begin
               if (half_done) begin
                  sdata_r <= sh_r[WORD_BITS-1];
                  sh_r <= {sh_r[WORD_BITS-2:0], 1'b0};
                  state_r <= ST_BIT;
               end
            end
            ST_BIT: begin
               if (half_done) begin
                  if (!sclk_r) begin
                     sclk_r <= 1'b1;
                  end else begin
                     sclk_r <= 1'b0;
                     if (bit_r == 6'(WORD_BITS - 1)) begin
                        state_r <= ST_LATCH; // R11
                     end else begin
                        bit_r <= bit_r + 6'h01;
                        sdata_r <= sh_r[WORD_BITS-1];
                        sh_r <= {sh_r[WORD_BITS-2:0], 1'b0};
                     end
                  end
               end
            end
            ST_LATCH: begin
               if (half_done) begin
                  latch_r <= 1'b1; // R11
                  busy_r <= 1'b0;
                  done_r <= 1'b1;
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Link outputs straight from flops
   assign link.sclk = sclk_r;
   assign link.sdata = sdata_r;
   assign link.latch_strobe = latch_r;
endmodule : prsl_wr

// File: shared/prsl_if.sv
/*
 * Three-wire serial load link between writer and device.
 * Assumes the writer drives every wire; the device only listens.
 */
`timescale 1ns/1ps
interface prsl_if;
   // ****************************************************
   // Link wires
   // ****************************************************
   logic sclk;
   logic sdata;
   logic latch_strobe;
   modport writer (output sclk, output sdata, output latch_strobe);
   modport device (input sclk, input sdata, input latch_strobe);
endinterface : prsl_if

// File: shared/prsl_pkg.sv
/*
 * Constants shared by both ends of the phase resync serial load block.
 * Assumes the three-wire link of clock, data and latch strobe only.
 */
// Behaviour
// R1: Dither off seeds modulator with phase word
// R2: Writer keeps phase word constant without table
// R3: Mode field 1,0 enables phase resync
// R4: Sync period is divider times modulus comparisons
// R5: Divider from register 3 bits 14:3, 1..4095
// R6: Modulus from register 1 bits 14:3
// R7: Second sync after strobe rise realigns phase
// R8: Writer picks period no shorter than lock
// R9: Phase word sets phase in 360/modulus steps
// R10: Shift on clock rise, latch word on strobe
// R11: Strobe low, four bytes, then strobe high
// R12: Resync gives one consistent phase offset
// R13: Mode field 0,1 runs fast-lock timer instead
// R14: Modulator steps once per comparison period
// R15: Timer restarts at each strobe rising edge
package prsl_pkg;
   // ****************************************************
   // Word layout
   // ****************************************************
   localparam int WORD_BITS = 32;
   localparam int BYTE_BITS = 8;
   localparam int ADDR_LSB = 0;
   localparam int ADDR_MSB = 2;
   localparam int NUM_LATCH = 6;
   localparam int FIELD_BITS = 12;
   localparam int FRAC_LSB = 3;
   localparam int DEN_LSB = 3;
   localparam int PHASE_LSB = 15;
   localparam int CDIV_LSB = 3;
   localparam int MODE_LSB = 15;
   localparam int REG_FRAC = 0;
   localparam int REG_DEN = 1;
   localparam int REG_CTRL = 3;
   // ****************************************************
   // Timer modes and timing
   // ****************************************************
   localparam logic [1:0] MODE_FASTLOCK = 2'h1;
   localparam logic [1:0] MODE_RESYNC = 2'h2;
   localparam int CLK_HZ = 40_000_000;
   localparam int CMP_HZ = 10_000_000;
   localparam int CMP_CYC = CLK_HZ / CMP_HZ;
   localparam int SCLK_HALF_NS = 100;
   localparam int SCLK_HALF_CYC = SCLK_HALF_NS * (CLK_HZ / 1_000_000) / 1000;
   localparam logic [31:0] LATCH_RESET = 32'h0000_0000;
endpackage : prsl_pkg

// File: test/prsl_monitor.sv
/*
 * Checker for the serial load link and the resync timer outputs.
 * Assumes it is instantiated beside the link with all three wires and the busy, done, sync, resync and mode outputs.
 */
`timescale 1ns/1ps
module prsl_monitor
   import prsl_pkg::*;
#(
   parameter int HALF = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Link wires
   input wire logic sclk,
   input wire logic sdata,
   input wire logic latch_strobe,
   // End outputs
   input wire logic busy_r,
   input wire logic done_r,
   input wire logic sync_pulse_r,
   input wire logic resync_r,
   input wire logic [1:0] mode_r
);
   // ****************************************************
   // Helper counters
   // ****************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic [5:0] bit_cnt_r;
   logic [7:0] hi_cnt_r;
   logic sclk_q_r;
   // Serial clock rises within one frame
   always_ff @(posedge clk) begin
      sclk_q_r <= sclk;
      if (reset || latch_strobe) begin
         bit_cnt_r <= 6'h00;
      end else if (sclk && !sclk_q_r) begin
         bit_cnt_r <= bit_cnt_r + 6'h01;
      end
   end
   // Cycles the serial clock has been high
   always_ff @(posedge clk) begin
      if (reset || !sclk) begin
         hi_cnt_r <= 8'h00;
      end else begin
         hi_cnt_r <= hi_cnt_r + 8'h01;
      end
   end
   // ****************************************************
   // Properties
   // ****************************************************
   sequence s_lead;
      (!sclk && !latch_strobe)[*2];
   endsequence
   sequence s_pulse;
      done_r ##1 !done_r;
   endsequence
   a_frame_lead: assert property ($fell(latch_strobe) |-> s_lead)
      else $error("serial clock moved too soon after strobe fell");
   a_strobe_busy: assert property (latch_strobe != busy_r)
      else $error("strobe level disagrees with busy");
   a_done_rise: assert property ($rose(latch_strobe) |-> s_pulse)
      else $error("done pulse missing at strobe rise");
   a_idle_sclk: assert property (latch_strobe |-> !sclk)
      else $error("serial clock high outside a frame");
   a_bit_count: assert property ($rose(latch_strobe) |-> bit_cnt_r == 6'h20)
      else $error("frame did not carry 32 bits");
   a_data_hold: assert property ($rose(sclk) |-> $stable(sdata))
      else $error("data changed at serial clock rise");
   a_sclk_high: assert property ($fell(sclk) |-> hi_cnt_r == 8'(HALF))
      else $error("serial clock high time wrong");
   a_resync_sync: assert property (resync_r |-> sync_pulse_r)
      else $error("realign without a sync pulse");
   a_sync_mode: assert property (sync_pulse_r |-> mode_r == MODE_RESYNC)
      else $error("sync pulse outside resync mode");
endmodule : prsl_monitor

// File: test/test_phase_resync_serial_load.sv
/*
 * Self-checking bench: writer and device joined by the link.
 * Assumes small divider settings so timer periods stay short.
 */
`timescale 1ns/1ps
module test_phase_resync_serial_load import prsl_pkg::*;;
   // ****************************************************
   // Signals and instances
   // ****************************************************
   localparam int TB_CMP = 2;
   localparam int TB_CDIV = 2;
   localparam int TB_DEN = 5;
   localparam int TB_PHASE = 7;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic start = 1'b0;
   logic dither_en = 1'b0;
   logic [WORD_BITS-1:0] word = 32'h0000_0000;
   logic busy_r, done_r, sync_pulse_r, resync_r, wide_bw_r, sigma_carry_r;
   logic [FIELD_BITS-1:0] phase_num_r, phase_den_r;
   logic [1:0] mode_r;
   int err_total = 0;
   int cmp_count = 0;
   int off_a, off_b, off_c;
   prsl_if prsl_if_i ();
   prsl_wr #(.HALF_CYC(2)) prsl_wr_i (.clk(clk), .reset(reset),
      .start(start), .word(word), .busy_r(busy_r), .done_r(done_r),
      .link(prsl_if_i.writer));
   prsl_dev #(.CMP_DIV(TB_CMP)) prsl_dev_i (.clk(clk), .reset(reset),
      .link(prsl_if_i.device), .dither_en(dither_en),
      .sync_pulse_r(sync_pulse_r), .resync_r(resync_r),
      .wide_bw_r(wide_bw_r), .sigma_carry_r(sigma_carry_r),
      .phase_num_r(phase_num_r), .phase_den_r(phase_den_r), .mode_r(mode_r));
   prsl_monitor #(.HALF(2)) prsl_monitor_i (.clk(clk), .reset(reset),
      .sclk(prsl_if_i.sclk), .sdata(prsl_if_i.sdata),
      .latch_strobe(prsl_if_i.latch_strobe), .busy_r(busy_r),
      .done_r(done_r), .sync_pulse_r(sync_pulse_r), .resync_r(resync_r),
      .mode_r(mode_r));
   // Clock generator
   initial begin
      forever #12.5 clk = ~clk;
   end
   // ****************************************************
   // Shared tasks
   // ****************************************************
   task check(input string name, input logic [11:0] exp,
      input logic [11:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // One latch word, waits for done under a bound
   task send(input logic [2:0] addr, input logic [11:0] hi,
      input logic [11:0] lo);
      int n;
      n = 0;
      @(posedge clk);
      start <= 1'b1;
      word <= {5'h00, hi, lo, addr};
      @(posedge clk);
      start <= 1'b0;
      while (done_r !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      check("done_r", 12'h001, {11'h000, done_r});
   endtask : send
   task wait_sync(output int cyc);
      cyc = 0;
      while (sync_pulse_r !== 1'b1 && cyc < 300) begin
         tick(1);
         cyc++;
      end
   endtask : wait_sync
   // ****************************************************
   // Scenarios
   // ****************************************************
   task sc_reset;
      check("sclk", 12'h000, {11'h000, prsl_if_i.sclk});
      check("latch_strobe", 12'h001,
         {11'h000, prsl_if_i.latch_strobe});
      check("phase_den_r", 12'h001, phase_den_r);
      check("mode_r", 12'h000, mode_r);
   endtask : sc_reset
   // Modulus, phase word, dropped address, fraction
   task sc_load;
      send(3'(REG_DEN), 12'(TB_PHASE), 12'(TB_DEN));
      tick(6);
      check("phase_num_r", 12'(TB_PHASE % TB_DEN), phase_num_r);
      check("phase_den_r", 12'(TB_DEN), phase_den_r);
      send(3'h6, 12'h001, 12'h009);
      tick(6);
      check("phase_den_r", 12'(TB_DEN), phase_den_r);
      send(3'(REG_FRAC), 12'h000, 12'h001);
   endtask : sc_load
   // Realign on second pulse, then offset to next carry
   task sc_resync(output int off);
      int n, pulses;
      n = 0;
      pulses = 0;
      send(3'(REG_CTRL), {10'h000, MODE_RESYNC}, 12'(TB_CDIV));
      tick(5);
      check("mode_r", {10'h000, MODE_RESYNC}, mode_r);
      while (resync_r !== 1'b1 && n < 300) begin
         if (sync_pulse_r === 1'b1) pulses++;
         tick(1);
         n++;
      end
      check("resync_r", 12'h001, {11'h000, resync_r});
      check("pulses_before", 12'h001, pulses[11:0]);
      off = 0;
      while (sigma_carry_r !== 1'b1 && off < 40) begin
         tick(1);
         off++;
      end
   endtask : sc_resync
   // Spacing of sync pulses and carry rate
   task sc_period;
      int a, b, c;
      c = 0;
      wait_sync(a);
      tick(1);
      wait_sync(b);
      check("resync_period", 12'(TB_CDIV * TB_DEN * TB_CMP), 12'(b + 1));
      repeat (200) begin
         if (sigma_carry_r === 1'b1) c++;
         tick(1);
      end
      check("carry_count", 12'(20), c[11:0]);
   endtask : sc_period
   // Wide bandwidth held until first expiry
   task sc_fast;
      int n;
      n = 0;
      send(3'(REG_CTRL), {10'h000, MODE_FASTLOCK}, 12'(TB_CDIV));
      tick(5);
      check("wide_bw_r", 12'h001, {11'h000, wide_bw_r});
      while (wide_bw_r === 1'b1 && n < 100) begin
         tick(1);
         n++;
      end
      check("wide_bw_r", 12'h000, {11'h000, wide_bw_r});
      check("wide_len", 12'h001, 12'(n > 10 && n < 30));
   endtask : sc_fast
   // ****************************************************
   // Sequence, watchdog and verdict
   // ****************************************************
   task close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      tick(4);
      sc_reset();
      sc_load();
      sc_resync(off_a);
      check("seed_offset", 12'(TB_CMP * (TB_DEN - TB_PHASE % TB_DEN)),
         off_a[11:0]);
      sc_period();
      sc_resync(off_b);
      check("carry_offset", off_a[11:0], off_b[11:0]);
      // Dither on: any seed, same carry rate
      @(posedge clk);
      dither_en <= 1'b1;
      sc_resync(off_c);
      check("dither_offset", 12'h001,
         12'(off_c >= TB_CMP && off_c <= TB_CMP * TB_DEN));
      sc_period();
      @(posedge clk);
      dither_en <= 1'b0;
      sc_fast();
      close_out();
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      close_out();
   end
endmodule : test_phase_resync_serial_load
